/* rcrf_pkg.sv */
// Constants, field layout and carrier types of the framer.
// Assumes one clock domain; body index n is frame byte offset n + 3.
package rcrf_pkg;
    localparam logic [7:0]  START_BYTE       = 8'h7E;
    localparam logic [7:0]  TYPE_REMOTE_REQ  = 8'h17;
    localparam logic [7:0]  TYPE_REMOTE_RSP  = 8'h97;
    localparam logic [7:0]  TYPE_EXPLICIT    = 8'h11;
    localparam logic [7:0]  TYPE_EXT_STATUS  = 8'h8B;
    localparam logic [7:0]  TYPE_RX_EXPLICIT = 8'h91;
    localparam logic [7:0]  TYPE_RX_PLAIN    = 8'h90;
    localparam logic [7:0]  FID_NO_RESPONSE  = 8'h00;
    localparam logic [7:0]  CSUM_BASE        = 8'hFF;
    localparam logic [7:0]  OPT_NO_ACK       = 8'h01;
    localparam logic [7:0]  OPT_APPLY        = 8'h02;
    localparam logic [7:0]  OPT_SECURE       = 8'h10;
    localparam logic [7:0]  RX_OPT_ACKED     = 8'h01;
    localparam logic [15:0] CLUSTER_LOOPBACK = 16'h0012;
    localparam logic [15:0] ADDR16_UNKNOWN   = 16'hFFFE;
    localparam int          IDX_TYPE         = 0;
    localparam int          IDX_FID          = 1;
    localparam int          IDX_DEST         = 2;
    localparam int          IDX_DEST_END     = 9;
    localparam int          IDX_REM_OPTS     = 12;
    localparam int          IDX_REM_CMD      = 13;
    localparam int          IDX_REM_VAL      = 15;
    localparam int          IDX_EXP_CLUSTER  = 14;
    localparam int          IDX_EXP_OPTS     = 19;
    localparam int          IDX_EXP_DATA     = 20;
    localparam int          BODY_MAX         = 20;
    localparam logic [4:0]  LEN_REM_RSP      = 5'd15;
    localparam logic [4:0]  LEN_EXT_STATUS   = 5'd7;
    localparam logic [4:0]  LEN_RX_ECHO      = 5'd12;
    localparam logic [7:0]  REG_CTRL         = 8'h00;
    localparam logic [7:0]  REG_DEFOPT       = 8'h04;
    localparam logic [7:0]  REG_STATUS       = 8'h08;
    localparam logic [7:0]  REG_MASK         = 8'h0C;
    localparam logic [7:0]  REG_LAST         = 8'h10;
    localparam logic        CTRL_RST         = 1'b0;
    localparam logic [7:0]  DEFOPT_RST       = 8'h00;
    localparam logic [3:0]  MASK_RST         = 4'h0;
    localparam int          ST_FRAME_OK      = 0;
    localparam int          ST_CKSUM_ERR     = 1;
    localparam int          ST_RESP_SENT     = 2;
    localparam int          ST_ECHO          = 3;

    typedef logic [BODY_MAX-1:0][7:0] rcrf_body_t;

    typedef struct packed {
        logic [7:0]  ftype;
        logic [7:0]  fid;
        logic [63:0] dest;
        logic [7:0]  opts;
        logic [15:0] cmd;
        logic [15:0] cluster;
        logic [15:0] plen;
    } rcrf_req_t;

    typedef struct packed {
        logic [63:0] dest;
        logic [15:0] cmd;
        logic [15:0] cluster;
        logic [7:0]  tx_opts;
        logic        remote;
        logic        no_ack;
        logic        apply;
        logic        secure;
        logic        query;
        logic        loopback;
    } rcrf_radio_t;

    typedef struct packed {
        logic [7:0]  status;
        logic [31:0] value;
        logic [2:0]  vlen;
    } rcrf_done_t;

    typedef enum logic [2:0] {
        RX_HUNT = 3'b000, RX_LEN_HI = 3'b001, RX_LEN_LO = 3'b011,
        RX_BODY = 3'b010, RX_CSUM = 3'b110, RX_HOLD = 3'b111
    } rcrf_rx_state_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000, TX_START = 3'b001, TX_LEN_HI = 3'b011,
        TX_LEN_LO = 3'b010, TX_BODY = 3'b110, TX_CSUM = 3'b111
    } rcrf_tx_state_t;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00, M_RADIO = 2'b01, M_SEND = 2'b11
    } rcrf_main_state_t;
endpackage

/* rcrf_rx.sv */
// Parser of host request frames.
// Assumes a core_clk byte stream; a frame is held until ack.
`timescale 1ns/1ps
`default_nettype none
module rcrf_rx (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic [7:0]         in_data,
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire logic               ack,
    output logic                    frame_valid,
    output logic                    good,
    output rcrf_pkg::rcrf_req_t     req,
    output logic [7:0]              pay_data,
    output logic                    pay_valid
);
    import rcrf_pkg::*;

    rcrf_rx_state_t state_reg;
    logic [15:0]    len_reg;
    logic [15:0]    cnt_reg;
    logic [7:0]     sum_reg;

    wire        take    = in_valid & in_ready;
    wire [15:0] len_in  = {len_reg[15:8], in_data};
    wire        is_rem  = req.ftype == TYPE_REMOTE_REQ;
    wire        is_exp  = req.ftype == TYPE_EXPLICIT;
    wire        at_dest = cnt_reg >= 16'(IDX_DEST) &&
                          cnt_reg <= 16'(IDX_DEST_END);
    wire        at_opts = (is_rem && cnt_reg == 16'(IDX_REM_OPTS)) ||
                          (is_exp && cnt_reg == 16'(IDX_EXP_OPTS));
    wire        at_cmd  = is_rem && (cnt_reg == 16'(IDX_REM_CMD) ||
                          cnt_reg == 16'(IDX_REM_CMD + 1));
    wire        at_clu  = is_exp && (cnt_reg == 16'(IDX_EXP_CLUSTER) ||
                          cnt_reg == 16'(IDX_EXP_CLUSTER + 1));
    wire        at_pay  = (is_rem && cnt_reg >= 16'(IDX_REM_VAL)) ||
                          (is_exp && cnt_reg >= 16'(IDX_EXP_DATA));
    wire [7:0]  csum_ok = CSUM_BASE - sum_reg;

    assign frame_valid = state_reg == RX_HOLD;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= RX_HUNT;
            in_ready  <= 1'b1;
            len_reg   <= '0;
            cnt_reg   <= '0;
            sum_reg   <= '0;
            good      <= 1'b0;
            req       <= '0;
            pay_data  <= '0;
            pay_valid <= 1'b0;
        end else begin
            pay_valid <= 1'b0;
            unique case (state_reg)
                RX_HUNT: if (take && in_data == START_BYTE) begin
                    state_reg <= RX_LEN_HI;
                end
                RX_LEN_HI: if (take) begin
                    len_reg[15:8] <= in_data;
                    state_reg     <= RX_LEN_LO;
                end
                RX_LEN_LO: if (take) begin
                    len_reg   <= len_in;
                    cnt_reg   <= '0;
                    sum_reg   <= '0;
                    req       <= '0;
                    state_reg <= (len_in == 16'h0000) ? RX_CSUM : RX_BODY;
                end
                RX_BODY: if (take) begin
                    sum_reg <= sum_reg + in_data;
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cnt_reg == 16'(IDX_TYPE)) begin
                        req.ftype <= in_data;
                    end
                    if (cnt_reg == 16'(IDX_FID)) begin
                        req.fid <= in_data;
                    end
                    if (at_dest) begin
                        req.dest <= {req.dest[55:0], in_data};
                    end
                    if (at_opts) begin
                        req.opts <= in_data;
                    end
                    if (at_cmd) begin
                        req.cmd <= {req.cmd[7:0], in_data};
                    end
                    if (at_clu) begin
                        req.cluster <= {req.cluster[7:0], in_data};
                    end
                    if (at_pay) begin
                        req.plen  <= req.plen + 16'h0001;
                        pay_data  <= in_data;
                        pay_valid <= 1'b1;
                    end
                    if (cnt_reg == len_reg - 16'h0001) begin
                        state_reg <= RX_CSUM;
                    end
                end
                RX_CSUM: if (take) begin
                    good      <= csum_ok == in_data;
                    in_ready  <= 1'b0;
                    state_reg <= RX_HOLD;
                end
                RX_HOLD: if (ack) begin
                    in_ready  <= 1'b1;
                    state_reg <= RX_HUNT;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* rcrf_tx.sv */
// Serialiser of response frames.
// Assumes the sink applies back-pressure through out_ready.
`timescale 1ns/1ps
`default_nettype none
module rcrf_tx (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                start,
    input  wire rcrf_pkg::rcrf_body_t body,
    input  wire logic [4:0]          blen,
    output logic                     busy,
    output logic [7:0]               out_data,
    output logic                     out_valid,
    input  wire logic                out_ready
);
    import rcrf_pkg::*;

    rcrf_tx_state_t state_reg;
    rcrf_body_t     body_reg;
    logic [4:0]     blen_reg;
    logic [4:0]     idx_reg;
    logic [7:0]     sum_reg;

    wire fire = out_valid & out_ready;

    assign busy = state_reg != TX_IDLE;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= TX_IDLE;
            body_reg  <= '0;
            blen_reg  <= '0;
            idx_reg   <= '0;
            sum_reg   <= '0;
            out_data  <= '0;
            out_valid <= 1'b0;
        end else begin
            unique case (state_reg)
                TX_IDLE: if (start) begin
                    body_reg  <= body;
                    blen_reg  <= blen;
                    out_data  <= START_BYTE;
                    out_valid <= 1'b1;
                    state_reg <= TX_START;
                end
                TX_START: if (fire) begin
                    out_data  <= 8'h00;
                    state_reg <= TX_LEN_HI;
                end
                TX_LEN_HI: if (fire) begin
                    out_data  <= {3'b000, blen_reg};
                    state_reg <= TX_LEN_LO;
                end
                TX_LEN_LO: if (fire) begin
                    out_data  <= body_reg[0];
                    sum_reg   <= body_reg[0];
                    idx_reg   <= 5'd1;
                    state_reg <= TX_BODY;
                end
                TX_BODY: if (fire) begin
                    if (idx_reg == blen_reg) begin
                        out_data  <= CSUM_BASE - sum_reg;
                        state_reg <= TX_CSUM;
                    end else begin
                        out_data <= body_reg[idx_reg];
                        sum_reg  <= sum_reg + body_reg[idx_reg];
                        idx_reg  <= idx_reg + 5'd1;
                    end
                end
                TX_CSUM: if (fire) begin
                    out_valid <= 1'b0;
                    state_reg <= TX_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* rcrf_top.sv */
// Request framer top: host parser, radio requests, answers, APB, irq.
// Assumes host and radio sides share core_clk and valid/ready.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module rcrf_top (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [7:0]            host_rx_data,
    input  wire logic                  host_rx_valid,
    output logic                       host_rx_ready,
    output logic [7:0]                 host_tx_data,
    output logic                       host_tx_valid,
    input  wire logic                  host_tx_ready,
    output rcrf_pkg::rcrf_radio_t      radio_req,
    output logic                       radio_req_valid,
    input  wire logic                  radio_req_ready,
    output logic [7:0]                 radio_pay_data,
    output logic                       radio_pay_valid,
    input  wire logic                  radio_done_valid,
    input  wire rcrf_pkg::rcrf_done_t  radio_done,
    input  wire logic                  radio_echo_valid,
    input  wire logic [63:0]           radio_echo_src,
    output logic                       irq
);
    import rcrf_pkg::*;

    rcrf_main_state_t state_reg;
    rcrf_req_t        cur_reg;
    rcrf_body_t       body_reg;
    logic [4:0]       blen_reg;
    logic             start_reg;
    logic             ack_reg;
    logic             echo_pend_reg;
    logic [63:0]      echo_src_reg;
    logic             ctrl_reg;
    logic [7:0]       defopt_reg;
    logic [3:0]       status_reg;
    logic [3:0]       status_next;
    logic [3:0]       mask_reg;
    logic [3:0]       ev_set;
    rcrf_body_t       rsp_body;
    logic [4:0]       rsp_len;
    rcrf_body_t       echo_body;

    // Frame parser.
    logic      frame_valid;
    logic      frame_good;
    rcrf_req_t frame;

    rcrf_rx u_rx (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .in_data     (host_rx_data),
        .in_valid    (host_rx_valid),
        .in_ready    (host_rx_ready),
        .ack         (ack_reg),
        .frame_valid (frame_valid),
        .good        (frame_good),
        .req         (frame),
        .pay_data    (radio_pay_data),
        .pay_valid   (radio_pay_valid)
    );

    // Response serialiser.
    logic tx_busy;

    rcrf_tx u_tx (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .start     (start_reg),
        .body      (body_reg),
        .blen      (blen_reg),
        .busy      (tx_busy),
        .out_data  (host_tx_data),
        .out_valid (host_tx_valid),
        .out_ready (host_tx_ready)
    );

    // APB decode. The slave answers in the first access cycle.
    wire apb_setup = psel & ~penable;
    wire apb_wr    = psel & penable & pready & pwrite;
    wire hit_ctrl  = paddr == REG_CTRL;
    wire hit_def   = paddr == REG_DEFOPT;
    wire hit_stat  = paddr == REG_STATUS;
    wire hit_mask  = paddr == REG_MASK;
    wire hit_last  = paddr == REG_LAST;
    wire hit_any   = hit_ctrl | hit_def | hit_stat | hit_mask | hit_last;
    wire [3:0] w1c = (apb_wr && hit_stat) ? pwdata[3:0] : 4'h0;

    wire [31:0] rd_mux =
        hit_ctrl ? {31'h0, ctrl_reg} :
        hit_def  ? {24'h0, defopt_reg} :
        hit_stat ? {28'h0, status_reg} :
        hit_mask ? {28'h0, mask_reg} :
        hit_last ? {16'h0, cur_reg.ftype, cur_reg.fid} : 32'h0;

    // Frame classification.
    wire take_frame = (state_reg == M_IDLE) && frame_valid && !ack_reg;
    wire is_rem     = frame.ftype == TYPE_REMOTE_REQ;
    wire is_exp     = frame.ftype == TYPE_EXPLICIT;
    wire [7:0] eff_opts =
        (is_exp && frame.opts == 8'h00) ? defopt_reg : frame.opts;
    wire want_rsp   = cur_reg.fid != FID_NO_RESPONSE;
    wire sent_done  = (state_reg == M_SEND) && !start_reg && !tx_busy;

    rcrf_radio_t radio_next;

    always_comb begin
        radio_next          = '0;
        radio_next.dest     = frame.dest;
        radio_next.cmd      = frame.cmd;
        radio_next.cluster  = frame.cluster;
        radio_next.tx_opts  = eff_opts;
        radio_next.remote   = is_rem;
        radio_next.no_ack   = |(eff_opts & OPT_NO_ACK);
        radio_next.apply    = is_rem && |(frame.opts & OPT_APPLY);
        radio_next.secure   = |(eff_opts & OPT_SECURE);
        radio_next.query    = is_rem && frame.plen == 16'h0000;
        radio_next.loopback = is_exp &&
                              frame.cluster == CLUSTER_LOOPBACK;
    end

    // Response body.
    always_comb begin
        rsp_body = '0;
        rsp_len  = LEN_EXT_STATUS;
        if (cur_reg.ftype == TYPE_REMOTE_REQ) begin
            rsp_body[0] = TYPE_REMOTE_RSP;
            rsp_body[1] = cur_reg.fid;
            for (int i = 0; i < 8; i++) begin
                rsp_body[2 + i] = cur_reg.dest[63 - 8 * i -: 8];
            end
            rsp_body[10] = ADDR16_UNKNOWN[15:8];
            rsp_body[11] = ADDR16_UNKNOWN[7:0];
            rsp_body[12] = cur_reg.cmd[15:8];
            rsp_body[13] = cur_reg.cmd[7:0];
            rsp_body[14] = radio_done.status;
            for (int i = 0; i < 4; i++) begin
                if (3'(i) < radio_done.vlen) begin
                    rsp_body[15 + i] = radio_done.value[31 - 8 * i -: 8];
                end
            end
            rsp_len = LEN_REM_RSP + 5'(radio_done.vlen);
        end else begin
            rsp_body[0] = TYPE_EXT_STATUS;
            rsp_body[1] = cur_reg.fid;
            rsp_body[2] = ADDR16_UNKNOWN[15:8];
            rsp_body[3] = ADDR16_UNKNOWN[7:0];
            rsp_body[5] = radio_done.status;
        end
    end

    // Receive frame for a returned loopback echo.
    always_comb begin
        echo_body    = '0;
        echo_body[0] = ctrl_reg ? TYPE_RX_EXPLICIT : TYPE_RX_PLAIN;
        for (int i = 0; i < 8; i++) begin
            echo_body[1 + i] = echo_src_reg[63 - 8 * i -: 8];
        end
        echo_body[9]  = ADDR16_UNKNOWN[15:8];
        echo_body[10] = ADDR16_UNKNOWN[7:0];
        echo_body[11] = RX_OPT_ACKED;
    end

    // Sticky events; a set in the clearing cycle wins.
    always_comb begin
        ev_set = 4'h0;
        ev_set[ST_FRAME_OK]  = take_frame && frame_good;
        ev_set[ST_CKSUM_ERR] = take_frame && !frame_good;
        ev_set[ST_RESP_SENT] = sent_done;
        ev_set[ST_ECHO]      = radio_echo_valid;
    end

    assign status_next = (status_reg & ~w1c) | ev_set;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= '0;
            ctrl_reg   <= CTRL_RST;
            defopt_reg <= DEFOPT_RST;
            mask_reg   <= MASK_RST;
            status_reg <= '0;
            irq        <= 1'b0;
        end else begin
            pready     <= apb_setup;
            pslverr    <= apb_setup && !hit_any;
            prdata     <= apb_setup ? rd_mux : 32'h0;
            status_reg <= status_next;
            irq        <= |(status_next & mask_reg);
            if (apb_wr && hit_ctrl) begin
                ctrl_reg <= pwdata[0];
            end
            if (apb_wr && hit_def) begin
                defopt_reg <= pwdata[7:0];
            end
            if (apb_wr && hit_mask) begin
                mask_reg <= pwdata[3:0];
            end
        end
    end

    // A returning echo waits while another answer is in flight.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            echo_pend_reg <= 1'b0;
            echo_src_reg  <= '0;
        end else if (radio_echo_valid) begin
            echo_pend_reg <= 1'b1;
            echo_src_reg  <= radio_echo_src;
        end else if (state_reg == M_IDLE && !take_frame) begin
            echo_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg       <= M_IDLE;
            cur_reg         <= '0;
            body_reg        <= '0;
            blen_reg        <= '0;
            start_reg       <= 1'b0;
            ack_reg         <= 1'b0;
            radio_req       <= '0;
            radio_req_valid <= 1'b0;
        end else begin
            ack_reg   <= take_frame;
            start_reg <= 1'b0;
            if (radio_req_valid && radio_req_ready) begin
                radio_req_valid <= 1'b0;
            end
            unique case (state_reg)
                M_IDLE: begin
                    if (take_frame) begin
                        if (frame_good && (is_rem || is_exp)) begin
                            cur_reg         <= frame;
                            radio_req       <= radio_next;
                            radio_req_valid <= 1'b1;
                            state_reg       <= M_RADIO;
                        end
                    end else if (echo_pend_reg) begin
                        body_reg  <= echo_body;
                        blen_reg  <= LEN_RX_ECHO;
                        start_reg <= 1'b1;
                        state_reg <= M_SEND;
                    end
                end
                M_RADIO: if (radio_done_valid) begin
                    if (want_rsp) begin
                        body_reg  <= rsp_body;
                        blen_reg  <= rsp_len;
                        start_reg <= 1'b1;
                        state_reg <= M_SEND;
                    end else begin
                        state_reg <= M_IDLE;
                    end
                end
                M_SEND: if (sent_done) begin
                    state_reg <= M_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* rcrf_sva.sv */
// Port checker of the framer: APB timing, response stream.
// Bound into rcrf_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module rcrf_sva import rcrf_pkg::*; (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  host_tx_data,
    input wire logic        host_tx_valid,
    input wire logic        host_tx_ready,
    input wire logic        radio_req_valid,
    input wire logic        radio_req_ready
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_setup; psel && !penable; endsequence
    sequence s_stall; host_tx_valid && !host_tx_ready; endsequence
    property p_sof;
        $rose(host_tx_valid) |-> host_tx_data == START_BYTE;
    endproperty
    a_sof: assert property (p_sof) else $error("frame lacks start");
    property p_hold;
        s_stall |=> host_tx_valid && $stable(host_tx_data);
    endproperty
    a_hold: assert property (p_hold) else $error("byte not held");
    property p_drop; $fell(host_tx_valid) |-> $past(host_tx_ready); endproperty
    a_drop: assert property (p_drop) else $error("byte withdrawn");
    property p_rdy; s_setup |=> pready ##1 !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("apb answer late");
    property p_acc; pready |-> psel && penable; endproperty
    a_acc: assert property (p_acc) else $error("stray pready");
    property p_err;
        pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > REG_LAST);
    endproperty
    a_err: assert property (p_err) else $error("wrong slave error");
    property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
    a_idle: assert property (p_idle) else $error("stray data");
    property p_req;
        radio_req_valid && !radio_req_ready |=> radio_req_valid;
    endproperty
    a_req: assert property (p_req) else $error("radio request dropped");
endmodule
bind rcrf_top rcrf_sva u_sva (.*);
`default_nettype wire

/* rcrf_host.sv */
// Host model: sends request bytes, sinks responses with stalls.
// Assumes whole frames are handed to send.
`timescale 1ns/1ps
`default_nettype none
module rcrf_host (
    input  wire logic       core_clk,
    output logic [7:0]      host_rx_data = 8'h00,
    output logic            host_rx_valid = 1'b0,
    input  wire logic       host_rx_ready,
    input  wire logic [7:0] host_tx_data,
    input  wire logic       host_tx_valid,
    output logic            host_tx_ready = 1'b0
);
    logic [7:0] got[$];
    logic [1:0] ph = 2'h0;
    // Every third cycle refuses a byte so the sender must hold it.
    always @(posedge core_clk) begin
        ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        host_tx_ready <= ph != 2'h2;
        if (host_tx_valid && host_tx_ready) got.push_back(host_tx_data);
    end
    task automatic send(input logic [7:0] f[$]);
        @(posedge core_clk);
        foreach (f[i]) begin
            host_rx_data <= f[i];
            host_rx_valid <= 1'b1;
            do @(posedge core_clk); while (!host_rx_ready);
        end
        host_rx_valid <= 1'b0;
        host_rx_data <= ~f[f.size()-1];
    endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Bench: random remote requests, an explicit request, APB, irq.
// Assumes the host model and checker compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("mismatch %0t %h %h", $time, a, e); end end
module testbench;
    import rcrf_pkg::*;
    typedef logic [7:0] rcrf_q8_t[$];
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 0, host_rx_data, host_tx_data, radio_pay_data, fid, op;
    logic [31:0] pwdata = 0, prdata, rd, seed = 32'h23D4E715;
    logic pready, pslverr, host_rx_valid, host_rx_ready, host_tx_valid, irq;
    logic host_tx_ready, radio_req_valid, radio_pay_valid;
    logic radio_req_ready = 0, radio_done_valid = 0, radio_echo_valid = 0;
    logic [63:0] radio_echo_src = 0, dst;
    rcrf_radio_t radio_req, rq;
    rcrf_done_t radio_done = '0;
    rcrf_q8_t b;
    int error_cnt = 0, total_checks = 0, nreq = 0, nr;
    rcrf_top dut (.*);
    rcrf_host host (.*);
    always #12.5 core_clk = ~core_clk;
    // Radio stand-in: done pulse right after each take.
    always @(posedge core_clk) begin
        radio_req_ready <= ~radio_req_ready;
        radio_done_valid <= radio_req_valid && radio_req_ready;
        if (radio_req_valid && radio_req_ready) begin
            rq <= radio_req;
            nreq <= nreq + 1;
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic rcrf_q8_t wrap(rcrf_q8_t f, logic bad);
        logic [7:0] s = CSUM_BASE;
        foreach (f[i]) s -= f[i];
        return {START_BYTE, 8'h00, 8'(f.size()), f, s ^ {7'h0, bad}};
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk) penable <= 1'b1;
        do @(posedge core_clk); while (!pready);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #(25 * 20000) error_cnt++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int n = 0; n < 7; n++) begin
            fid = (n == 2) ? FID_NO_RESPONSE : 8'(xs());
            op = 8'(xs()) & (OPT_NO_ACK | OPT_APPLY | OPT_SECURE);
            dst = {xs(), xs()};
            radio_done <= '{8'(xs()), 32'h0, 3'h0};
            b = {TYPE_REMOTE_REQ, fid};
            for (int i = 7; i >= 0; i--) b.push_back(dst[i*8+:8]);
            b = {b, 8'hFF, 8'hFE, op, 8'h54, 8'h50};
            if (n % 2 == 1) b.push_back(8'(xs()));
            host.got.delete();
            nr = nreq;
            host.send(wrap(b, n == 4));
            repeat (80) @(posedge core_clk);
            `CHK(nreq, nr + (n != 4))
            if (n != 4) begin
                `CHK({rq.no_ack, rq.apply, rq.secure}, {op[0], op[1], op[4]})
                `CHK({rq.dest, rq.query}, {dst, n % 2 == 0})
            end
            b = wrap({TYPE_REMOTE_RSP, fid, b[2:11], b[13:14], radio_done.status}, 1'b0);
            if (fid == 8'h00 || n == 4) b.delete();
            `CHK(host.got.size(), b.size())
            foreach (b[i]) `CHK(host.got[i], b[i])
        end
        apb(1'b1, REG_DEFOPT, 32'h41);
        b = {TYPE_EXPLICIT, 8'h5A, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
             8'h07, 8'h08, 8'hFF, 8'hFE, 8'hE8, 8'hE8, 8'h00, 8'h12, 8'hC1,
             8'h05, 8'h00, 8'h00, 8'h54};
        host.got.delete();
        host.send(wrap(b, 1'b0));
        repeat (80) @(posedge core_clk);
        `CHK({rq.tx_opts, rq.loopback}, {8'h41, 1'b1})
        b = wrap({TYPE_EXT_STATUS, 8'h5A, 8'hFF, 8'hFE, 8'h00,
                  radio_done.status, 8'h00}, 1'b0);
        foreach (b[i]) `CHK(host.got[i], b[i])
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK({rd[3:0], irq}, {4'h7, 1'b0})
        apb(1'b1, REG_MASK, 32'h2);
        repeat (3) @(negedge core_clk);
        `CHK(irq, 1'b1)
        apb(1'b1, REG_STATUS, 32'h2);
        repeat (3) @(negedge core_clk);
        `CHK(irq, 1'b0)
        apb(1'b0, 8'h40, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        finish_test();
    end
endmodule
`default_nettype wire
